// [shared/icp_map.svh]
// Address map, field positions, reset values and timing counts of the isolated input port
// Functional notes
// - Byte reads return inputs 1-32 at 0..3
// - Wide jumper allows 16-bit reads at 0, 2
// - Lowest input of a group at bit 0
// - Inputs readable at once after reset
// - Events on 1-16; AND only for 1-8
// - One request, routed by jumper to a line
// - Five causes raise the request
// - Event on level change or combined change
// - Run-down flagged when count passes 1 to 0
// - Three programmable 16-bit down counters
// - Counter signal, gate, trigger on fixed inputs
// - Timer mode counts jumper-selected reference
// - Gate from software or input; halts counting
// - Trigger from software or input; reloads start
// - Software inits, starts, stops, reads counters
// - Cause mask bits 0x1 to 0x10
`ifndef ICP_MAP_SVH
`define ICP_MAP_SVH
// Offsets in the I/O window
`define ICP_OFF_IN0 5'h00
`define ICP_OFF_IN1 5'h01
`define ICP_OFF_IN2 5'h02
`define ICP_OFF_IN3 5'h03
`define ICP_OFF_EV_CTRL 5'h04
`define ICP_OFF_EV_MASK1 5'h05
`define ICP_OFF_EV_MASK2 5'h06
`define ICP_OFF_CAUSE 5'h07
`define ICP_OFF_CNT_BASE 5'h08
`define ICP_OFF_CNT_END 5'h14
// Counter slice sub-offsets
`define ICP_CSUB_LO 2'h0
`define ICP_CSUB_HI 2'h1
`define ICP_CSUB_CTRL 2'h2
`define ICP_CSUB_CMD 2'h3
// Event control and command field positions
`define ICP_EV_EN1 0
`define ICP_EV_AND1 1
`define ICP_EV_EN2 2
`define ICP_CMD_INIT 0
`define ICP_CMD_TRIG 1
// Cause bit positions
`define ICP_CAUSE_EV1 0
`define ICP_CAUSE_EV2 1
`define ICP_CAUSE_CNT0 2
// Jumper vector positions
`define ICP_JMP_WIDE 0
`define ICP_JMP_REF 1
// Input channel of each counter, counter 0 in the low field, 0-based
`define ICP_SIG_CH {5'h11, 5'h09, 5'h0D}
`define ICP_GATE_CH {5'h13, 5'h0B, 5'h0F}
`define ICP_TRIG_CH {5'h12, 5'h0A, 5'h0E}
// Reset values
`define ICP_EV_CTRL_RST 3'h0
`define ICP_EV_MASK_RST 8'hFF
`define ICP_RELOAD_RST 16'hFFFF
// Timing
`define ICP_CLK_PERIOD_NS 8
`define ICP_REF0_PERIOD_NS 1000
`define ICP_REF1_PERIOD_NS 10000
`define ICP_REF0_DIV ((`ICP_REF0_PERIOD_NS + `ICP_CLK_PERIOD_NS - 1) / `ICP_CLK_PERIOD_NS)
`define ICP_REF1_DIV ((`ICP_REF1_PERIOD_NS + `ICP_CLK_PERIOD_NS - 1) / `ICP_CLK_PERIOD_NS)
`endif

// [shared/icp_pkg.sv]
// Types shared by the isolated input port modules
package icp_pkg;
  // Counter control byte
  typedef struct packed {
    logic trig_inv;
    logic trig_src;
    logic gate_sw;
    logic gate_inv;
    logic gate_src;
    logic timer;
    logic run;
  } icp_cnt_ctrl_t;
  // Counter status seen by software
  typedef enum logic [1:0] {
    ICP_CS_IDLE = 2'b00,
    ICP_CS_COUNT = 2'b01,
    ICP_CS_HELD = 2'b10,
    ICP_CS_DONE = 2'b11
  } icp_cnt_state_t;
  // State of one counter slice
  typedef struct packed {
    logic [15:0] count;
    logic sig_prev;
    logic trig_prev;
    logic rundown;
    icp_cnt_state_t state;
  } icp_cnt_reg_t;
  // State of the port top
  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [4:0] jsync1;
    logic [4:0] jsync2;
    logic [15:0] ev_prev;
    logic [2:0] ev_ctrl;
    logic [7:0] ev_mask1;
    logic [7:0] ev_mask2;
    logic [4:0] cause;
    logic [2:0][15:0] reload;
    icp_cnt_ctrl_t [2:0] ctrl;
    logic [2:0] init;
    logic [2:0] trig_sw;
    logic [2:0][7:0] hi_latch;
    logic [15:0] pre;
    logic ref_tick;
    logic [15:0] rdata;
    logic rvalid;
    logic [6:0] irq;
  } icp_top_reg_t;
endpackage

// [shared/icp_if.sv]
// Interfaces between the port top and its counter and event slices
`timescale 1ns/10ps
interface icp_cnt_if;
  icp_pkg::icp_cnt_ctrl_t ctrl; // Programmed mode
  logic [15:0] reload; // Start value
  logic init; // Load start value pulse
  logic trig_sw; // Software trigger pulse
  logic ref_tick; // Timer reference tick
  logic sig_in; // Synchronised signal channel
  logic gate_in; // Synchronised gate channel
  logic trig_in; // Synchronised trigger channel
  logic [15:0] count; // Current count
  logic rundown; // One-cycle run-down pulse
  icp_pkg::icp_cnt_state_t state; // Slice status
  modport top (output ctrl, reload, init, trig_sw, ref_tick, sig_in, gate_in, trig_in,
    input count, rundown, state);
  modport cnt (input ctrl, reload, init, trig_sw, ref_tick, sig_in, gate_in, trig_in,
    output count, rundown, state);
endinterface

interface icp_evt_if;
  logic and_mode; // Combine by AND instead of OR
  logic [7:0] mask; // Channels taking part
  logic [7:0] cur; // Present levels
  logic [7:0] prev; // Levels one cycle earlier
  logic hit; // Event seen this cycle
  modport top (output and_mode, mask, cur, prev, input hit);
  modport evt (input and_mode, mask, cur, prev, output hit);
endinterface

// [verilog/icp_event.sv]
// Change-of-state detector for one group of eight channels
`timescale 1ns/10ps
module icp_event
(
  icp_evt_if.evt bus
);
  logic and_cur; // Combined AND of masked channels now
  logic and_prev; // Combined AND one cycle earlier

  // -----------------------------------------------------------
  // Event decision
  // -----------------------------------------------------------
  always_comb
  begin
    and_cur = &(bus.cur | ~bus.mask);
    and_prev = &(bus.prev | ~bus.mask);
    // AND: only a change of the combined result counts
    if (bus.and_mode)
    begin
      bus.hit = (and_cur != and_prev);
    end
    // OR: any edge on any masked channel counts
    else
    begin
      bus.hit = |((bus.cur ^ bus.prev) & bus.mask);
    end
  end
endmodule

// [verilog/icp_counter.sv]
// One 16-bit down counter/timer slice with gate, trigger and run-down pulse
`timescale 1ns/10ps
module icp_counter
(
  input wire logic clock,
  input wire logic resetn,
  icp_cnt_if.cnt bus
);
  icp_pkg::icp_cnt_reg_t s_ff; // Slice state
  icp_pkg::icp_cnt_reg_t nxt_s; // Next slice state
  logic gate_on; // Counting held
  logic trig_on; // Trigger level after polarity
  logic load; // Reload this cycle
  logic step; // One decrement request

  // -----------------------------------------------------------
  // Next state
  // -----------------------------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    gate_on = bus.ctrl.gate_src ? (bus.gate_in ^ bus.ctrl.gate_inv) : bus.ctrl.gate_sw;
    trig_on = bus.ctrl.trig_src & (bus.trig_in ^ bus.ctrl.trig_inv);
    load = bus.init | bus.trig_sw | (trig_on & ~s_ff.trig_prev);
    step = bus.ctrl.timer ? bus.ref_tick : (bus.sig_in & ~s_ff.sig_prev);
    nxt_s.sig_prev = bus.sig_in;
    nxt_s.trig_prev = trig_on;
    nxt_s.rundown = 1'b0;
    // Reload wins over counting
    if (load)
    begin
      nxt_s.count = bus.reload;
    end
    // Decrement, stopping at zero
    else if (bus.ctrl.run && !gate_on && step && s_ff.count != 16'h0000)
    begin
      nxt_s.count = s_ff.count - 16'h0001;
      nxt_s.rundown = (s_ff.count == 16'h0001);
    end
    // Status for readback
    if (nxt_s.count == 16'h0000)
      nxt_s.state = icp_pkg::ICP_CS_DONE;
    else if (!bus.ctrl.run)
      nxt_s.state = icp_pkg::ICP_CS_IDLE;
    else if (gate_on)
      nxt_s.state = icp_pkg::ICP_CS_HELD;
    else
      nxt_s.state = icp_pkg::ICP_CS_COUNT;
  end

  // Register the slice
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      s_ff <= '{count: 16'h0000, sig_prev: 1'b0, trig_prev: 1'b0, rundown: 1'b0,
        state: icp_pkg::ICP_CS_DONE};
    else
      s_ff <= nxt_s;
  end

  assign bus.count = s_ff.count;
  assign bus.rundown = s_ff.rundown;
  assign bus.state = s_ff.state;

  // -----------------------------------------------------------
  // Checks
  // -----------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_rundown;
    s_ff.rundown |-> s_ff.count == 16'h0000 && $past(s_ff.count) == 16'h0001;
  endproperty
  a_rundown: assert property (p_rundown) else $error("run-down without 1 to 0");
  property p_gate_hold;
    bus.ctrl.run && gate_on && !load |=> $stable(s_ff.count);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("count moved under gate");
  property p_reload;
    load |=> s_ff.count == $past(bus.reload);
  endproperty
  a_reload: assert property (p_reload) else $error("trigger did not reload");
  property p_floor;
    s_ff.count == 16'h0000 && !load |=> s_ff.count == 16'h0000;
  endproperty
  a_floor: assert property (p_floor) else $error("counter wrapped below zero");
endmodule

// [verilog/icp_port.sv]
// Top of the isolated 32-channel input port with events and counters
`timescale 1ns/10ps
`include "icp_map.svh"
module icp_port
#(
  parameter logic [15:0] REF0_DIV = 16'(`ICP_REF0_DIV), // Clocks per reference tick, jumper off
  parameter logic [15:0] REF1_DIV = 16'(`ICP_REF1_DIV) // Clocks per reference tick, jumper on
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [31:0] din,
  input wire logic wide_access_jumper,
  input wire logic timer_reference_jumper,
  input wire logic [2:0] irq_route_jumper,
  input wire logic [4:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic io_wide,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  output logic io_rvalid,
  output logic [6:0] irq_line
);
  // -----------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------
  icp_pkg::icp_top_reg_t s_ff; // All port state
  icp_pkg::icp_top_reg_t nxt_s; // Next port state
  logic [2:0][15:0] cnt_count; // Counts from the slices
  logic [2:0] cnt_rundown; // Run-down pulses from the slices
  logic [2:0][1:0] cnt_state; // Slice status codes
  logic [1:0] ev_hit; // Event pulses from the groups
  logic wide_ok; // Wide cycle allowed by jumper
  logic [4:0] cnt_off; // Offset inside the counter block
  logic [1:0] cnt_idx; // Selected counter
  logic [1:0] cnt_sub; // Register inside the slice
  logic cnt_hit; // Access falls on a counter slice
  logic [4:0] cause_set; // Causes raised this cycle
  logic [4:0] cause_clr; // Causes cleared by software
  logic [15:0] ref_div; // Active reference divider
  logic [14:0] sig_ch; // Signal channel numbers
  logic [14:0] gate_ch; // Gate channel numbers
  logic [14:0] trig_ch; // Trigger channel numbers
  logic irq_req; // Any cause pending

  icp_cnt_if cnt_bus [3] (); // Links to the counter slices
  icp_evt_if ev_bus [2] (); // Links to the event groups

  assign sig_ch = `ICP_SIG_CH;
  assign gate_ch = `ICP_GATE_CH;
  assign trig_ch = `ICP_TRIG_CH;

  // -----------------------------------------------------------
  // Counter slices
  // -----------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_cnt
      // Channels are fixed per slice
      assign cnt_bus[gi].sig_in = s_ff.sync2[sig_ch[gi*5 +: 5]];
      assign cnt_bus[gi].gate_in = s_ff.sync2[gate_ch[gi*5 +: 5]];
      assign cnt_bus[gi].trig_in = s_ff.sync2[trig_ch[gi*5 +: 5]];
      assign cnt_bus[gi].ctrl = s_ff.ctrl[gi];
      assign cnt_bus[gi].reload = s_ff.reload[gi];
      assign cnt_bus[gi].init = s_ff.init[gi];
      assign cnt_bus[gi].trig_sw = s_ff.trig_sw[gi];
      assign cnt_bus[gi].ref_tick = s_ff.ref_tick;
      assign cnt_count[gi] = cnt_bus[gi].count;
      assign cnt_rundown[gi] = cnt_bus[gi].rundown;
      assign cnt_state[gi] = cnt_bus[gi].state;
      // One slice per counter
      icp_counter u_cnt
      (
        .clock(clock),
        .resetn(resetn),
        .bus(cnt_bus[gi])
      );
    end
  endgenerate

  // -----------------------------------------------------------
  // Event groups
  // -----------------------------------------------------------
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_evt
      // Only the first group may combine by AND
      assign ev_bus[gi].and_mode = (gi == 0) ? s_ff.ev_ctrl[`ICP_EV_AND1] : 1'b0;
      assign ev_bus[gi].mask = (gi == 0) ? s_ff.ev_mask1 : s_ff.ev_mask2;
      assign ev_bus[gi].cur = s_ff.sync2[gi*8 +: 8];
      assign ev_bus[gi].prev = s_ff.ev_prev[gi*8 +: 8];
      assign ev_hit[gi] = ev_bus[gi].hit;
      // Change-of-state detector
      icp_event u_evt
      (
        .bus(ev_bus[gi])
      );
    end
  endgenerate

  // -----------------------------------------------------------
  // Next state
  // -----------------------------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    // Pins and jumpers pass two flops before use
    nxt_s.sync1 = din;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.jsync1 = {irq_route_jumper, timer_reference_jumper, wide_access_jumper};
    nxt_s.jsync2 = s_ff.jsync1;
    // Previous levels for change detection
    nxt_s.ev_prev = s_ff.sync2[15:0];
    wide_ok = io_wide && s_ff.jsync2[`ICP_JMP_WIDE];
    cnt_off = io_addr - `ICP_OFF_CNT_BASE;
    cnt_idx = cnt_off[3:2];
    cnt_sub = cnt_off[1:0];
    cnt_hit = (io_addr >= `ICP_OFF_CNT_BASE) && (io_addr < `ICP_OFF_CNT_END);
    // Command pulses last one cycle
    nxt_s.init = 3'h0;
    nxt_s.trig_sw = 3'h0;
    cause_clr = 5'h00;

    // Reference prescaler for timer mode
    ref_div = s_ff.jsync2[`ICP_JMP_REF] ? REF1_DIV : REF0_DIV;
    if (s_ff.pre >= ref_div - 16'h0001)
    begin
      nxt_s.pre = 16'h0000;
      nxt_s.ref_tick = 1'b1;
    end
    else
    begin
      nxt_s.pre = s_ff.pre + 16'h0001;
      nxt_s.ref_tick = 1'b0;
    end

    // Read path, answer one cycle later
    nxt_s.rvalid = io_rd;
    if (io_rd)
    begin
      nxt_s.rdata = 16'h0000;
      // Input bytes and words, no side effect
      if (io_addr <= `ICP_OFF_IN3)
      begin
        if (wide_ok && !io_addr[0])
          nxt_s.rdata = s_ff.sync2[io_addr[1]*16 +: 16];
        else
          nxt_s.rdata = {8'h00, s_ff.sync2[io_addr[1:0]*8 +: 8]};
      end
      // Event and cause registers
      else if (io_addr == `ICP_OFF_EV_CTRL)
        nxt_s.rdata = {13'h0000, s_ff.ev_ctrl};
      else if (io_addr == `ICP_OFF_EV_MASK1)
        nxt_s.rdata = {8'h00, s_ff.ev_mask1};
      else if (io_addr == `ICP_OFF_EV_MASK2)
        nxt_s.rdata = {8'h00, s_ff.ev_mask2};
      else if (io_addr == `ICP_OFF_CAUSE)
        nxt_s.rdata = {11'h000, s_ff.cause};
      // Counter slices
      else if (cnt_hit)
      begin
        case (cnt_sub)
          `ICP_CSUB_LO:
          begin
            // Whole word at once, or low byte with high byte latched
            if (wide_ok)
              nxt_s.rdata = cnt_count[cnt_idx];
            else
            begin
              nxt_s.rdata = {8'h00, cnt_count[cnt_idx][7:0]};
              nxt_s.hi_latch[cnt_idx] = cnt_count[cnt_idx][15:8];
            end
          end
          `ICP_CSUB_HI:
            nxt_s.rdata = {8'h00, s_ff.hi_latch[cnt_idx]};
          `ICP_CSUB_CTRL:
            nxt_s.rdata = {9'h000, s_ff.ctrl[cnt_idx]};
          `ICP_CSUB_CMD:
            nxt_s.rdata = {14'h0000, cnt_state[cnt_idx]};
          default:
            nxt_s.rdata = 16'h0000;
        endcase
      end
      // Unmapped offsets read as zero
      else
        nxt_s.rdata = 16'h0000;
    end

    // Write path
    if (io_wr)
    begin
      // Event configuration
      if (io_addr == `ICP_OFF_EV_CTRL)
        nxt_s.ev_ctrl = io_wdata[2:0];
      else if (io_addr == `ICP_OFF_EV_MASK1)
        nxt_s.ev_mask1 = io_wdata[7:0];
      else if (io_addr == `ICP_OFF_EV_MASK2)
        nxt_s.ev_mask2 = io_wdata[7:0];
      // Writing ones clears causes
      else if (io_addr == `ICP_OFF_CAUSE)
        cause_clr = io_wdata[4:0];
      // Counter programming
      else if (cnt_hit)
      begin
        case (cnt_sub)
          `ICP_CSUB_LO:
          begin
            if (wide_ok)
              nxt_s.reload[cnt_idx] = io_wdata;
            else
              nxt_s.reload[cnt_idx][7:0] = io_wdata[7:0];
          end
          `ICP_CSUB_HI:
            nxt_s.reload[cnt_idx][15:8] = io_wdata[7:0];
          `ICP_CSUB_CTRL:
            nxt_s.ctrl[cnt_idx] = io_wdata[6:0];
          `ICP_CSUB_CMD:
          begin
            nxt_s.init[cnt_idx] = io_wdata[`ICP_CMD_INIT];
            nxt_s.trig_sw[cnt_idx] = io_wdata[`ICP_CMD_TRIG];
          end
          default:
            nxt_s.init = 3'h0;
        endcase
      end
    end

    // Causes: a new event wins over a clear in the same cycle
    cause_set = {cnt_rundown, ev_hit[1] & s_ff.ev_ctrl[`ICP_EV_EN2],
      ev_hit[0] & s_ff.ev_ctrl[`ICP_EV_EN1]};
    nxt_s.cause = (s_ff.cause & ~cause_clr) | cause_set;

    // Single request steered to the jumpered line
    irq_req = |s_ff.cause;
    for (int k = 0; k < 7; k++)
    begin
      nxt_s.irq[k] = irq_req && (s_ff.jsync2[4:2] == 3'(k));
    end
  end

  // -----------------------------------------------------------
  // State register
  // -----------------------------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s_ff <= '0;
      s_ff.ev_ctrl <= `ICP_EV_CTRL_RST;
      s_ff.ev_mask1 <= `ICP_EV_MASK_RST;
      s_ff.ev_mask2 <= `ICP_EV_MASK_RST;
      s_ff.reload <= {3{`ICP_RELOAD_RST}};
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from flops
  assign io_rdata = s_ff.rdata;
  assign io_rvalid = s_ff.rvalid;
  assign irq_line = s_ff.irq;

  // -----------------------------------------------------------
  // Checks
  // -----------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Byte read of inputs 9-16 lands on the low lane
  property p_byte_read;
    io_rd && !wide_ok && io_addr == `ICP_OFF_IN1 |=>
      io_rvalid && io_rdata == {8'h00, $past(s_ff.sync2[15:8])};
  endproperty
  a_byte_read: assert property (p_byte_read) else $error("byte read wrong");

  // Input 4 lands on bit 3 of the first byte
  property p_bit_order;
    io_rd && !wide_ok && io_addr == `ICP_OFF_IN0 |=>
      io_rdata[3] == $past(s_ff.sync2[3]) && io_rdata[15:8] == 8'h00;
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("bit order wrong");

  // Wide read of inputs 17-32
  property p_wide_read;
    io_rd && wide_ok && io_addr == `ICP_OFF_IN2 |=> io_rdata == $past(s_ff.sync2[31:16]);
  endproperty
  a_wide_read: assert property (p_wide_read) else $error("wide read wrong");

  // At most one request line
  property p_one_line;
    $onehot0(irq_line);
  endproperty
  a_one_line: assert property (p_one_line) else $error("several lines driven");

  // Pending cause raises the routed line
  property p_irq_follow;
    (|s_ff.cause) && s_ff.jsync2[4:2] != 3'h7 |=>
      irq_line == 7'(7'h01 << $past(s_ff.jsync2[4:2]));
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("request not raised");

  // Run-down of counter 1 shows as 0x4
  property p_cnt_cause;
    cnt_rundown[0] |=> s_ff.cause[`ICP_CAUSE_CNT0];
  endproperty
  a_cnt_cause: assert property (p_cnt_cause) else $error("run-down cause lost");

  // OR event on group 1 sets its cause
  property p_or_event;
    s_ff.ev_ctrl[`ICP_EV_EN1] && !s_ff.ev_ctrl[`ICP_EV_AND1] &&
      (|((s_ff.sync2[7:0] ^ s_ff.ev_prev[7:0]) & s_ff.ev_mask1)) |=>
      s_ff.cause[`ICP_CAUSE_EV1];
  endproperty
  a_or_event: assert property (p_or_event) else $error("group 1 event lost");

  // Pin change reaches the read path after two flops
  property p_sync;
    ##1 $changed(din) |-> ##2 s_ff.sync2 == $past(din, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("input not synchronised");

  // Reading input offsets leaves latches alone
  property p_inert_read;
    io_rd && io_addr <= `ICP_OFF_IN3 |=> $stable(s_ff.hi_latch);
  endproperty
  a_inert_read: assert property (p_inert_read) else $error("input read had effect");
endmodule

// [verif/icp_host.sv]
// Host model that issues byte and word I/O cycles to the input port
`timescale 1ns/10ps
module icp_host
(
  input wire logic clock,
  output logic [4:0] io_addr,
  output logic io_rd,
  output logic io_wr,
  output logic io_wide,
  output logic [15:0] io_wdata,
  input wire logic [15:0] io_rdata,
  input wire logic io_rvalid
);
  // ------------------------------------------
  // Bus cycles, launched on the falling edge
  // ------------------------------------------
  initial
  begin
    io_addr = 5'h1F;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wide = 1'b0;
    io_wdata = 16'h0000;
  end
  // Read: answer is taken one cycle after the strobe; wide only with jumper fitted
  task automatic rd(input logic [4:0] a, input logic w, output logic [15:0] d);
    @(negedge clock);
    io_addr = a;
    io_wide = w;
    io_rd = 1'b1;
    @(negedge clock);
    io_rd = 1'b0;
    io_addr = ~a;
    d = io_rvalid ? io_rdata : 16'hDEAD;
  endtask
  // Write: one strobe cycle, then the data lines stop showing the value
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clock);
    io_addr = a;
    io_wide = 1'b0;
    io_wdata = v;
    io_wr = 1'b1;
    @(negedge clock);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~v;
  endtask
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the isolated input port
`timescale 1ns/10ps
module tb_top;
  logic clock;
  logic resetn;
  logic [31:0] din;
  logic [2:0] route;
  logic wide_j; // Wide access jumper level
  logic ref_j; // Timer reference jumper level
  logic [4:0] io_addr;
  logic io_rd;
  logic io_wr;
  logic io_wide;
  logic [15:0] io_wdata;
  logic [15:0] io_rdata;
  logic io_rvalid;
  logic [6:0] irq_line;
  logic [15:0] d;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // ------------------------------------------
  // Design, host model and clock
  // ------------------------------------------
  icp_port #(.REF0_DIV(16'h0004), .REF1_DIV(16'h0008)) dut (.clock(clock), .resetn(resetn),
    .din(din), .wide_access_jumper(wide_j), .timer_reference_jumper(ref_j),
    .irq_route_jumper(route), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wide(io_wide), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .irq_line(irq_line));
  icp_host host (.clock(clock), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wide(io_wide), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Cuts a hang short
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      complete_run();
    end
  end
  // ------------------------------------------
  // Shared checks
  // ------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reads a register and compares it
  task automatic rchk(input logic [4:0] a, input logic w, input logic [15:0] exp);
    host.rd(a, w, d);
    chk(d, exp);
  endtask
  // Lets synchroniser and cause logic settle
  task automatic settle();
    repeat (6) @(negedge clock);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial
  begin
    int m;
    resetn = 1'b0;
    din = 32'h0000_0000;
    route = 3'h1;
    wide_j = 1'b1;
    ref_j = 1'b0;
    m = $urandom(32'h38C5);
    repeat (20) @(negedge clock);
    resetn = 1'b1;
    repeat (3) @(negedge clock);
    // Random inputs read as bytes and words with no setup writes
    for (int i = 0; i < 6; i++)
    begin
      din = $urandom;
      m = din;
      settle();
      for (int k = 0; k < 4; k++)
        rchk(5'(k), 1'b0, 16'((m >> (8 * k)) & 'hFF));
      rchk(5'h00, 1'b1, 16'(m & 'hFFFF));
      rchk(5'h02, 1'b1, 16'((m >> 16) & 'hFFFF));
    end
    // Wide cycle with the jumper off falls back to a byte
    wide_j = 1'b0;
    settle();
    rchk(5'h02, 1'b1, 16'((m >> 16) & 'hFF));
    wide_j = 1'b1;
    $display("test inputs done");
    // OR events on both groups, cause clearing and routed request
    din = 32'h0000_0000;
    settle();
    host.wr(5'h07, 16'h001F);
    host.wr(5'h04, 16'h0005);
    din[3] = 1'b1;
    settle();
    rchk(5'h07, 1'b0, 16'h0001);
    chk(16'(irq_line), 16'h0002);
    host.wr(5'h07, 16'h001F);
    din[9] = 1'b1;
    settle();
    rchk(5'h07, 1'b0, 16'h0002);
    host.wr(5'h07, 16'h001F);
    settle();
    chk(16'(irq_line), 16'h0000);
    // AND on group one: only the change of the combined level counts
    host.wr(5'h04, 16'h0003);
    din[7:0] = 8'h7F;
    settle();
    rchk(5'h07, 1'b0, 16'h0000);
    din[7:0] = 8'hFF;
    settle();
    rchk(5'h07, 1'b0, 16'h0001);
    host.wr(5'h07, 16'h001F);
    $display("test events done");
    // Counter one counts input 14 down from 3 to run-down
    host.wr(5'h08, 16'h0003);
    host.wr(5'h09, 16'h0000);
    host.wr(5'h0A, 16'h0001);
    host.wr(5'h0B, 16'h0001);
    settle();
    m = 3;
    for (int p = 0; p < 3; p++)
    begin
      din[13] = 1'b1;
      settle();
      din[13] = 1'b0;
      settle();
      m--;
      rchk(5'h08, 1'b0, 16'(m));
      rchk(5'h09, 1'b0, 16'h0000);
    end
    rchk(5'h07, 1'b0, 16'h0004);
    chk(16'(irq_line), 16'h0002);
    $display("test counter done");
    // Timer three: reference ticks, gate on input 20, trigger on input 19
    host.wr(5'h07, 16'h001F);
    din[19] = 1'b1;
    ref_j = 1'b1;
    host.wr(5'h10, 16'h0005);
    host.wr(5'h11, 16'h0000);
    host.wr(5'h12, 16'h0027);
    host.wr(5'h13, 16'h0001);
    settle();
    rchk(5'h10, 1'b1, 16'h0005);
    rchk(5'h13, 1'b0, 16'h0002);
    // Sixteen ungated clocks hold exactly two slow reference ticks
    din[19] = 1'b0;
    repeat (16) @(negedge clock);
    din[19] = 1'b1;
    settle();
    rchk(5'h10, 1'b1, 16'h0003);
    ref_j = 1'b0;
    din[19] = 1'b0;
    repeat (40) @(negedge clock);
    rchk(5'h10, 1'b1, 16'h0000);
    rchk(5'h07, 1'b0, 16'h0010);
    // Rising trigger input reloads the start value under gate
    din[19] = 1'b1;
    din[18] = 1'b1;
    settle();
    rchk(5'h10, 1'b1, 16'h0005);
    $display("test timer done");
    complete_run();
  end
endmodule
